// ---- sar_adc_pkg.sv ----
// constants, register map and types of the converter control block
`default_nettype none
package sar_adc_pkg;
    // bus shape
    localparam int ADDR_W = 8;
    localparam int DATA_W = 32;
    // register byte offsets
    localparam logic [7:0] OFF_CTRL = 8'h00;
    localparam logic [7:0] OFF_SAMPLE = 8'h04;
    localparam logic [7:0] OFF_CONV = 8'h08;
    localparam logic [7:0] OFF_CMD = 8'h0c;
    localparam logic [7:0] OFF_STATUS = 8'h10;
    localparam logic [7:0] OFF_IRQ_STAT = 8'h14;
    localparam logic [7:0] OFF_IRQ_CLR = 8'h18;
    localparam logic [7:0] OFF_IRQ_EN = 8'h1c;
    localparam logic [7:0] OFF_RESULT0 = 8'h20;
    localparam logic [7:0] OFF_LAST = 8'h30;
    // control fields
    localparam int CTRL_W = 12;
    localparam int CTRL_EN = 0;
    localparam int CTRL_MODE = 1;
    localparam int CTRL_SCAN = 3;
    localparam int CTRL_CONT = 4;
    localparam int CTRL_TRIG = 5;
    localparam int CTRL_SRC = 7;
    localparam logic [CTRL_W-1:0] CTRL_RST = 12'h000;
    // command fields
    localparam int CMD_START = 0;
    localparam int CMD_STOP = 1;
    // interrupt status layout
    localparam int IRQ_W = 3;
    localparam int IRQ_CONV_END = 0;
    localparam int IRQ_PASS_END = 1;
    localparam int IRQ_TRIG_LOST = 2;
    // trigger modes
    typedef logic [1:0] trig_mode_t;
    localparam trig_mode_t MODE_SW = 2'h0;
    localparam trig_mode_t MODE_HW_NOWAIT = 2'h1;
    localparam trig_mode_t MODE_HW_WAIT = 2'h2;
    localparam int TRIG_N = 4;
    // conversion source codes
    localparam int SRC_W = 5;
    typedef logic [SRC_W-1:0] src_t;
    localparam src_t SRC_UNUSED_CH = 5'h0d;
    localparam src_t SRC_LAST_CH = 5'h0f;
    localparam src_t SRC_SCAN_TOP = 5'h0c;
    localparam src_t SRC_TEMP = 5'h10;
    localparam src_t SRC_VREF_INT = 5'h11;
    localparam src_t SRC_REF_POS = 5'h12;
    localparam src_t SRC_REF_NEG = 5'h13;
    localparam src_t SRC_GAIN_ZERO = 5'h14;
    localparam src_t SRC_GAIN_ONE = 5'h15;
    // result and scan
    localparam int RES_W = 12;
    localparam int SCAN_N = 4;
    localparam logic [1:0] SCAN_LAST = 2'h3;
    // phase lengths in half converter clocks
    localparam int HALF_W = 8;
    localparam logic [HALF_W-1:0] SAMPLE_HALF_RST = 8'h1b;
    localparam logic [HALF_W-1:0] CONV_HALF_MIN = 8'h3f;
    // core cycles per half converter clock
    localparam logic [3:0] CLK_DIV_HALF = 4'h2;
    // power stabilisation wait
    localparam int CORE_PERIOD_NS = 4;
    localparam int PWR_STAB_NS = 1000;
    localparam int TMR_W = 16;
    localparam logic [TMR_W-1:0] PWR_STAB_CYC =
        TMR_W'((PWR_STAB_NS + CORE_PERIOD_NS - 1) / CORE_PERIOD_NS);
    // sequencer states
    typedef enum logic [3:0] {
        ST_IDLE = 4'b0001,
        ST_PWR = 4'b0010,
        ST_SAMPLE = 4'b0100,
        ST_CONV = 4'b1000
    } state_e;
endpackage
`default_nettype wire

// ---- phase_timer.sv ----
// down counter that times one phase and pulses when it ends
`default_nettype none
module phase_timer
    import sar_adc_pkg::*;
(
    // clock and reset
    input wire logic core_clk_i,
    input wire logic reset_n_i,
    // control
    input wire logic load_i,
    input wire logic [TMR_W-1:0] value_i,
    input wire logic tick_i,
    // result
    output logic done_o
);
    logic [TMR_W-1:0] count;

    // count ticks, zero length behaves as one
    always_ff @(posedge core_clk_i) begin
        if (!reset_n_i) begin
            count <= '0;
        end else if (load_i) begin
            count <= (value_i == '0) ? TMR_W'(1) : value_i;
        end else if (tick_i && count != '0) begin
            count <= count - TMR_W'(1);
        end
    end

    always_ff @(posedge core_clk_i) begin
        if (!reset_n_i) begin
            done_o <= 1'b0;
        end else begin
            done_o <= !load_i && tick_i && count == TMR_W'(1);
        end
    end
endmodule // phase_timer
`default_nettype wire

// ---- sar_adc_ctrl.sv ----
// sequencer and register file of the 12-bit converter control
//
// What this block does
// - drives 12-bit converter, sources 0..15 external, index 13 refused in select mode
// - software mode starts only on a software start command
// - hardware no-wait mode starts at once on trigger, power already on
// - hardware wait mode keeps converter unpowered; trigger turns power on
// - after wait-mode trigger, waits power settling then starts by itself
// - select mode routes exactly one chosen source per conversion
// - scan mode converts four consecutive channels from start channel 0..12, higher starts clamped to 12
// - single mode runs one pass then stops
// - continuous mode repeats passes until software stops it
// - sampling length programmable in half clocks, reset 13.5 clocks
// - conversion never shorter than 31.5 converter clocks
// - internal reference and temperature sensor are selectable sources
// - self-test sources: both references, channels, sensor, internal reference
// - either gain amplifier output is a selectable source
//
// The Avalon-MM register port and the register offsets were decided locally.
`default_nettype none
module sar_adc_ctrl
    import sar_adc_pkg::*;
(
    // clock and reset
    input wire logic core_clk_i,
    input wire logic reset_n_i,
    // avalon-mm slave
    input wire logic [sar_adc_pkg::ADDR_W-1:0] address_i,
    input wire logic read_i,
    input wire logic write_i,
    input wire logic [sar_adc_pkg::DATA_W-1:0] writedata_i,
    input wire logic [3:0] byteenable_i,
    output logic [sar_adc_pkg::DATA_W-1:0] readdata_o,
    output logic waitrequest_o,
    // hardware trigger pins
    input wire logic [sar_adc_pkg::TRIG_N-1:0] hw_trig_i,
    // analog core and input multiplexer
    input wire logic [sar_adc_pkg::RES_W-1:0] adc_result_i,
    output logic adc_power_o,
    output logic adc_clk_o,
    output logic adc_sample_o,
    output logic adc_convert_o,
    output logic [sar_adc_pkg::SRC_W-1:0] source_sel_o,
    // interrupt
    output logic irq_o
);
    import sar_adc_pkg::*;

    state_e state;
    state_e next_state;
    logic [CTRL_W-1:0] ctrl;
    logic [HALF_W-1:0] sample_half;
    logic [HALF_W-1:0] conv_half;
    logic [IRQ_W-1:0] irq_stat;
    logic [IRQ_W-1:0] irq_en;
    logic [RES_W-1:0] result [SCAN_N];
    logic [RES_W-1:0] last_result;
    logic [1:0] idx;
    src_t chan;
    logic [TRIG_N-1:0] trig_s1;
    logic [TRIG_N-1:0] trig_s2;
    logic [TRIG_N-1:0] trig_s3;
    logic [TRIG_N-1:0] trig_lvl;
    logic [3:0] div_cnt;
    logic half_tick;

    // configuration views
    logic en;
    trig_mode_t mode;
    logic scan;
    logic cont;
    logic [1:0] trig_sel;
    src_t src;
    src_t scan_base;
    logic cfg_ok;
    logic [HALF_W-1:0] conv_len;

    assign en = ctrl[CTRL_EN];
    assign mode = ctrl[CTRL_MODE +: 2];
    assign scan = ctrl[CTRL_SCAN];
    assign cont = ctrl[CTRL_CONT];
    assign trig_sel = ctrl[CTRL_TRIG +: 2];
    assign src = ctrl[CTRL_SRC +: SRC_W];

    assign scan_base = (src > SRC_SCAN_TOP) ? SRC_SCAN_TOP : src;

    always_comb begin
        if (scan) begin
            cfg_ok = 1'b1;
        end else begin
            cfg_ok = (src != SRC_UNUSED_CH) && (src <= SRC_GAIN_ONE);
        end
    end

    assign conv_len = (conv_half < CONV_HALF_MIN) ? CONV_HALF_MIN : conv_half;

    // bus decode
    logic wr_go;
    logic rd_load;
    logic start_cmd;
    logic stop_cmd;
    logic [DATA_W-1:0] wmask;

    assign wr_go = write_i && !waitrequest_o;
    assign rd_load = read_i && waitrequest_o;
    assign wmask = {{8{byteenable_i[3]}}, {8{byteenable_i[2]}},
                    {8{byteenable_i[1]}}, {8{byteenable_i[0]}}};

    function automatic logic [DATA_W-1:0] merge(input logic [DATA_W-1:0] old_v,
                                                input logic [DATA_W-1:0] new_v,
                                                input logic [DATA_W-1:0] m);
        merge = (old_v & ~m) | (new_v & m);
    endfunction

    assign start_cmd = wr_go && address_i == OFF_CMD && byteenable_i[0]
                       && writedata_i[CMD_START];
    assign stop_cmd = wr_go && address_i == OFF_CMD && byteenable_i[0]
                      && writedata_i[CMD_STOP];

    // one wait cycle per access
    always_ff @(posedge core_clk_i) begin
        if (!reset_n_i) begin
            waitrequest_o <= 1'b1;
        end else begin
            waitrequest_o <= !((read_i || write_i) && waitrequest_o);
        end
    end

    // writable registers
    always_ff @(posedge core_clk_i) begin
        if (!reset_n_i) begin
            ctrl <= CTRL_RST;
            sample_half <= SAMPLE_HALF_RST;
            conv_half <= CONV_HALF_MIN;
            irq_en <= '0;
        end else if (wr_go) begin
            unique case (address_i)
                OFF_CTRL: ctrl <= CTRL_W'(merge(DATA_W'(ctrl), writedata_i, wmask));
                OFF_SAMPLE: sample_half <= HALF_W'(merge(DATA_W'(sample_half), writedata_i, wmask));
                OFF_CONV: conv_half <= HALF_W'(merge(DATA_W'(conv_half), writedata_i, wmask));
                OFF_IRQ_EN: irq_en <= IRQ_W'(merge(DATA_W'(irq_en), writedata_i, wmask));
                default: begin
                end
            endcase
        end
    end

    // read data, unmapped reads zero
    always_ff @(posedge core_clk_i) begin
        if (!reset_n_i) begin
            readdata_o <= '0;
        end else if (rd_load) begin
            readdata_o <= '0;
            unique case (address_i)
                OFF_CTRL: readdata_o <= DATA_W'(ctrl);
                OFF_SAMPLE: readdata_o <= DATA_W'(sample_half);
                OFF_CONV: readdata_o <= DATA_W'(conv_half);
                OFF_STATUS: readdata_o <= DATA_W'({chan, idx, !cfg_ok, state, adc_power_o});
                OFF_IRQ_STAT: readdata_o <= DATA_W'(irq_stat);
                OFF_IRQ_EN: readdata_o <= DATA_W'(irq_en);
                OFF_LAST: readdata_o <= DATA_W'(last_result);
                default: begin
                    if (address_i[7:4] == OFF_RESULT0[7:4] && address_i[1:0] == 2'h0) begin
                        readdata_o <= DATA_W'(result[address_i[3:2]]);
                    end
                end
            endcase
        end
    end

    // trigger pin synchronisers
    always_ff @(posedge core_clk_i) begin
        if (!reset_n_i) begin
            trig_s1 <= '0;
            trig_s2 <= '0;
            trig_s3 <= '0;
        end else begin
            trig_s1 <= hw_trig_i;
            trig_s2 <= trig_s1;
            trig_s3 <= trig_s2;
        end
    end

    // level changes once two stages agree
    always_ff @(posedge core_clk_i) begin
        if (!reset_n_i) begin
            trig_lvl <= '0;
        end else begin
            for (int i = 0; i < TRIG_N; i++) begin
                if (trig_s2[i] == trig_s3[i]) begin
                    trig_lvl[i] <= trig_s3[i];
                end
            end
        end
    end

    logic hw_event;
    assign hw_event = trig_s2[trig_sel] && trig_s3[trig_sel] && !trig_lvl[trig_sel]
                      && mode != MODE_SW;

    // sequencer timing
    logic phase_load;
    logic [TMR_W-1:0] phase_val;
    logic phase_done;
    logic pwr_load;
    logic pwr_done;
    logic begin_pass;
    logic conv_end;
    logic pass_end;
    logic abort;

    assign abort = stop_cmd || !en;
    assign conv_end = (state == ST_CONV) && phase_done && !abort;
    assign pass_end = conv_end && (!scan || idx == SCAN_LAST);

    always_comb begin
        next_state = state;
        begin_pass = 1'b0;
        pwr_load = 1'b0;
        phase_load = 1'b0;
        phase_val = TMR_W'(sample_half);
        unique case (state)
            ST_IDLE: begin
                if (en && cfg_ok) begin
                    if (mode == MODE_SW && start_cmd) begin
                        begin_pass = 1'b1;
                    end
                    if (mode == MODE_HW_NOWAIT && hw_event) begin
                        begin_pass = 1'b1;
                    end
                    if (mode == MODE_HW_WAIT && hw_event) begin
                        pwr_load = 1'b1;
                        next_state = ST_PWR;
                    end
                end
            end
            ST_PWR: begin
                if (pwr_done) begin
                    begin_pass = 1'b1;
                end
            end
            ST_SAMPLE: begin
                if (phase_done) begin
                    phase_load = 1'b1;
                    phase_val = TMR_W'(conv_len);
                    next_state = ST_CONV;
                end
            end
            ST_CONV: begin
                if (conv_end) begin
                    if (pass_end && !cont) begin
                        next_state = ST_IDLE;
                    end else begin
                        phase_load = 1'b1;
                        next_state = ST_SAMPLE;
                    end
                end
            end
        endcase
        if (begin_pass) begin
            phase_load = 1'b1;
            next_state = ST_SAMPLE;
        end
        if (abort) begin
            next_state = ST_IDLE;
            begin_pass = 1'b0;
            phase_load = 1'b0;
            pwr_load = 1'b0;
        end
    end

    always_ff @(posedge core_clk_i) begin
        if (!reset_n_i) begin
            state <= ST_IDLE;
        end else begin
            state <= next_state;
        end
    end

    // half converter clock enable, restarted with each phase
    always_ff @(posedge core_clk_i) begin
        if (!reset_n_i || phase_load) begin
            div_cnt <= '0;
            half_tick <= 1'b0;
        end else if (div_cnt == CLK_DIV_HALF - 4'h1) begin
            div_cnt <= '0;
            half_tick <= 1'b1;
        end else begin
            div_cnt <= div_cnt + 4'h1;
            half_tick <= 1'b0;
        end
    end

    phase_timer u_phase (
        .core_clk_i(core_clk_i),
        .reset_n_i(reset_n_i),
        .load_i(phase_load),
        .value_i(phase_val),
        .tick_i(half_tick),
        .done_o(phase_done)
    );

    phase_timer u_power (
        .core_clk_i(core_clk_i),
        .reset_n_i(reset_n_i),
        .load_i(pwr_load),
        .value_i(PWR_STAB_CYC),
        .tick_i(1'b1),
        .done_o(pwr_done)
    );

    // channel pointer
    always_ff @(posedge core_clk_i) begin
        if (!reset_n_i) begin
            idx <= '0;
            chan <= '0;
        end else if (begin_pass || (conv_end && pass_end)) begin
            idx <= '0;
            chan <= scan ? scan_base : src;
        end else if (conv_end) begin
            idx <= idx + 2'h1;
            chan <= chan + src_t'(1);
        end
    end

    always_ff @(posedge core_clk_i) begin
        if (!reset_n_i) begin
            for (int i = 0; i < SCAN_N; i++) begin
                result[i] <= '0;
            end
            last_result <= '0;
        end else if (conv_end) begin
            result[idx] <= adc_result_i;
            last_result <= adc_result_i;
        end
    end

    // sticky events, set wins over clear
    logic [IRQ_W-1:0] irq_set;
    logic [IRQ_W-1:0] irq_clr;

    always_comb begin
        irq_set = '0;
        irq_set[IRQ_CONV_END] = conv_end;
        irq_set[IRQ_PASS_END] = pass_end;
        irq_set[IRQ_TRIG_LOST] = hw_event && en && state != ST_IDLE;
        irq_clr = '0;
        if (wr_go && address_i == OFF_IRQ_CLR) begin
            irq_clr = IRQ_W'(writedata_i & wmask);
        end
    end

    always_ff @(posedge core_clk_i) begin
        if (!reset_n_i) begin
            irq_stat <= '0;
        end else begin
            irq_stat <= (irq_stat & ~irq_clr) | irq_set;
        end
    end

    always_ff @(posedge core_clk_i) begin
        if (!reset_n_i) begin
            irq_o <= 1'b0;
        end else begin
            irq_o <= |(irq_stat & irq_en);
        end
    end

    // analog side outputs
    always_ff @(posedge core_clk_i) begin
        if (!reset_n_i) begin
            adc_power_o <= 1'b0;
            adc_sample_o <= 1'b0;
            adc_convert_o <= 1'b0;
            source_sel_o <= '0;
        end else begin
            adc_power_o <= en && (mode != MODE_HW_WAIT || next_state != ST_IDLE);
            adc_sample_o <= next_state == ST_SAMPLE;
            adc_convert_o <= next_state == ST_CONV;
            source_sel_o <= (begin_pass || (conv_end && pass_end))
                            ? (scan ? scan_base : src)
                            : (conv_end ? chan + src_t'(1) : chan);
        end
    end

    // converter clock toggles each half period while busy
    always_ff @(posedge core_clk_i) begin
        if (!reset_n_i) begin
            adc_clk_o <= 1'b0;
        end else if (state == ST_IDLE || state == ST_PWR) begin
            adc_clk_o <= 1'b0;
        end else if (half_tick) begin
            adc_clk_o <= !adc_clk_o;
        end
    end
endmodule // sar_adc_ctrl
`default_nettype wire

// ---- sar_adc_ctrl_assertions.sv ----
// concurrent checks on the converter control ports
`default_nettype none
module sar_adc_ctrl_assertions
    import sar_adc_pkg::*;
(
    // clock and reset
    input wire logic core_clk_i,
    input wire logic reset_n_i,
    // avalon-mm slave
    input wire logic read_i,
    input wire logic write_i,
    input wire logic waitrequest_o,
    // analog core and input multiplexer
    input wire logic adc_power_o,
    input wire logic adc_clk_o,
    input wire logic adc_sample_o,
    input wire logic adc_convert_o,
    input wire logic [sar_adc_pkg::SRC_W-1:0] source_sel_o
);
    timeunit 1ns;
    timeprecision 1ps;
    default clocking cb @(posedge core_clk_i); endclocking
    default disable iff (!reset_n_i);
    logic [7:0] conv_cnt;
    // length of the running conversion phase
    always_ff @(posedge core_clk_i) begin
        if (!reset_n_i || !adc_convert_o) begin
            conv_cnt <= 8'h00;
        end else if (conv_cnt != 8'hff) begin
            conv_cnt <= conv_cnt + 8'h01;
        end
    end
    sequence s_no_abort;
        !$past(write_i) && !$past(write_i, 2) && !$past(write_i, 3);
    endsequence
    sequence s_sample_end;
        $fell(adc_sample_o) ##0 s_no_abort;
    endsequence
    sequence s_conv_follows;
        ##[0:2] adc_convert_o;
    endsequence
    property p_wait_answer;
        (read_i || write_i) && waitrequest_o |=> !waitrequest_o;
    endproperty
    property p_wait_stand;
        !waitrequest_o |=> waitrequest_o;
    endproperty
    property p_wait_idle;
        !(read_i || write_i) |-> waitrequest_o;
    endproperty
    property p_powered;
        (adc_sample_o || adc_convert_o) |-> adc_power_o;
    endproperty
    property p_phase_excl;
        !(adc_sample_o && adc_convert_o);
    endproperty
    property p_phase_order;
        s_sample_end |-> s_conv_follows;
    endproperty
    property p_sel_hold;
        adc_convert_o |-> $stable(source_sel_o);
    endproperty
    property p_src_range;
        adc_sample_o |-> source_sel_o <= SRC_GAIN_ONE;
    endproperty
    property p_conv_len;
        $fell(adc_convert_o) ##0 s_no_abort |-> conv_cnt >= 8'h7e;
    endproperty
    property p_clk_runs;
        adc_sample_o && $past(adc_sample_o, 5) |-> adc_clk_o != $past(adc_clk_o, 2);
    endproperty
    property p_clk_quiet;
        !adc_sample_o && !adc_convert_o && !$past(adc_sample_o) && !$past(adc_convert_o) |-> !adc_clk_o;
    endproperty
    a_wait_answer: assert property (p_wait_answer) else $error("no answer one cycle after request");
    a_wait_stand: assert property (p_wait_stand) else $error("waitrequest low longer than one cycle");
    a_wait_idle: assert property (p_wait_idle) else $error("waitrequest low without request");
    a_powered: assert property (p_powered) else $error("phase active while unpowered");
    a_phase_excl: assert property (p_phase_excl) else $error("sample and convert together");
    a_phase_order: assert property (p_phase_order) else $error("no conversion after sampling");
    a_sel_hold: assert property (p_sel_hold) else $error("source changed in conversion");
    a_src_range: assert property (p_src_range) else $error("source code out of range");
    a_conv_len: assert property (p_conv_len) else $error("conversion phase too short");
    a_clk_quiet: assert property (p_clk_quiet) else $error("converter clock runs while idle");
    a_clk_runs: assert property (p_clk_runs) else $error("converter clock stalls while sampling");
endmodule // sar_adc_ctrl_assertions
bind sar_adc_ctrl sar_adc_ctrl_assertions sar_adc_ctrl_assertions_inst (
    .core_clk_i(core_clk_i),
    .reset_n_i(reset_n_i),
    .read_i(read_i),
    .write_i(write_i),
    .waitrequest_o(waitrequest_o),
    .adc_power_o(adc_power_o),
    .adc_clk_o(adc_clk_o),
    .adc_sample_o(adc_sample_o),
    .adc_convert_o(adc_convert_o),
    .source_sel_o(source_sel_o)
);
`default_nettype wire

// ---- sar_adc_core_model.sv ----
// behavioural analog core: result follows the routed source
`default_nettype none
module sar_adc_core_model
    import sar_adc_pkg::*;
(
    // converter control
    input wire logic power_i,
    input wire logic convert_i,
    input wire logic [sar_adc_pkg::SRC_W-1:0] source_sel_i,
    // result
    output logic [sar_adc_pkg::RES_W-1:0] result_o
);
    timeunit 1ns;
    timeprecision 1ps;
    logic [RES_W-1:0] level;
    assign level = {source_sel_i, 7'h2b};
    // valid only while powered and converting
    assign result_o = (power_i && convert_i) ? level : ~level;
endmodule // sar_adc_core_model
`default_nettype wire

// ---- sar_adc_ctrl_tb.sv ----
// self-checking testbench of the converter control
`default_nettype none
module sar_adc_ctrl_tb;
    timeunit 1ns;
    timeprecision 1ps;
    import sar_adc_pkg::*;
    logic core_clk = 1'b0;
    logic reset_n = 1'b0;
    logic [7:0] address = 8'h00;
    logic rd = 1'b0;
    logic wr = 1'b0;
    logic [31:0] wdata = 32'h0;
    logic [31:0] rdata;
    logic waitreq;
    logic [3:0] hw_trig = 4'h0;
    logic [11:0] adc_result;
    logic adc_power, adc_clk, adc_sample, adc_convert, irq;
    logic [4:0] source_sel;
    logic [31:0] q;
    logic smp_d = 1'b0;
    logic conv_d = 1'b0;
    logic [4:0] seen_src[$];
    int errors = 0;
    int num_checks = 0;
    int cyc = 0;
    int nsmp = 0;
    int nend = 0;
    int srun = 0;
    int crun = 0;
    int k, t0;
    typedef struct {logic [4:0] src; logic [11:0] res;} row_s;
    row_s rows[10] = '{'{5'h00, 12'h02b}, '{5'h0c, 12'h62b}, '{5'h0e, 12'h72b}, '{5'h0f, 12'h7ab},
        '{5'h10, 12'h82b}, '{5'h11, 12'h8ab}, '{5'h12, 12'h92b}, '{5'h13, 12'h9ab},
        '{5'h14, 12'ha2b}, '{5'h15, 12'haab}};
    always #2 core_clk = ~core_clk;
    sar_adc_ctrl sar_adc_ctrl_inst (.core_clk_i(core_clk), .reset_n_i(reset_n), .address_i(address),
        .read_i(rd), .write_i(wr), .writedata_i(wdata), .byteenable_i(4'hf), .readdata_o(rdata),
        .waitrequest_o(waitreq), .hw_trig_i(hw_trig), .adc_result_i(adc_result), .adc_power_o(adc_power),
        .adc_clk_o(adc_clk), .adc_sample_o(adc_sample), .adc_convert_o(adc_convert),
        .source_sel_o(source_sel), .irq_o(irq));
    sar_adc_core_model sar_adc_core_model_inst (.power_i(adc_power), .convert_i(adc_convert),
        .source_sel_i(source_sel), .result_o(adc_result));
    // phase monitor and timeout
    always @(posedge core_clk) begin
        cyc++;
        if (adc_sample && !smp_d) begin
            nsmp++;
            seen_src.push_back(source_sel);
            srun = 0;
        end
        if (adc_convert && !conv_d) crun = 0;
        srun += int'(adc_sample);
        crun += int'(adc_convert);
        if (!adc_convert && conv_d) nend++;
        smp_d = adc_sample;
        conv_d = adc_convert;
        if (cyc == 20000) begin
            errors++;
            wrap_up();
        end
    end
    task automatic wrap_up();
        $display("checks %0d errors %0d", num_checks, errors);
        if (errors == 0 && num_checks > 0) begin
            $display("SIMULATION PASSED");
        end else begin
            $display("SIMULATION FAILED");
        end
        $finish;
    endtask
    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        num_checks++;
        if (seen !== exp) begin
            errors++;
            $display("ERROR t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask
    task automatic bus(input logic w, input logic [7:0] a, input logic [31:0] d);
        @(posedge core_clk);
        address <= a;
        wr <= w;
        rd <= !w;
        wdata <= d;
        do begin
            @(posedge core_clk);
        end while (waitreq !== 1'b0);
        q = rdata;
        rd <= 1'b0;
        wr <= 1'b0;
    endtask
    function automatic logic [31:0] ctl(input logic [1:0] m, input logic sc, input logic co,
        input logic [1:0] tg, input logic [4:0] s);
        return 32'({s, tg, co, sc, m, 1'b1});
    endfunction
    task automatic wait_for(input bit ends, input int target);
        while ((ends ? nend : nsmp) < target) begin
            @(posedge core_clk);
        end
        repeat (4) @(posedge core_clk);
    endtask
    task automatic trig(input int i);
        hw_trig <= 4'(1 << i);
        repeat (4) @(posedge core_clk);
        hw_trig <= 4'h0;
    endtask
    task automatic run_one(input logic [31:0] c, input int convs);
        seen_src.delete();
        bus(1'b1, OFF_CTRL, c);
        check(32'(seen_src.size()), 32'h0);
        bus(1'b1, OFF_CMD, 32'h1);
        wait_for(1'b1, nend + convs);
    endtask
    initial begin
        repeat (6) @(posedge core_clk);
        reset_n <= 1'b1;
        bus(1'b0, OFF_CTRL, 0); check(q, 32'h0);
        bus(1'b0, OFF_SAMPLE, 0); check(q, 32'h1b);
        bus(1'b0, OFF_CONV, 0); check(q, 32'h3f);
        bus(1'b0, OFF_IRQ_EN, 0); check(q, 32'h0);
        bus(1'b1, 8'h40, 32'hffff_ffff);
        bus(1'b0, 8'h40, 0); check(q, 32'h0);
        check(32'({irq, adc_power}), 32'h0);
        bus(1'b1, OFF_IRQ_EN, 32'h1);
        foreach (rows[i]) begin
            run_one(ctl(MODE_SW, 1'b0, 1'b0, 2'h0, rows[i].src), 1);
            check(32'(seen_src.size()), 32'h1);
            check(32'(seen_src[0]), 32'(rows[i].src));
            check(32'(srun inside {[54:58]}), 32'h1);
            check(32'(crun >= 126), 32'h1);
            check(32'(irq), 32'h1);
            bus(1'b0, OFF_RESULT0, 0); check(q, 32'(rows[i].res));
            bus(1'b0, OFF_LAST, 0); check(q, 32'(rows[i].res));
            bus(1'b1, OFF_IRQ_CLR, 32'h7);
            bus(1'b0, OFF_IRQ_STAT, 0); check(q, 32'h0);
            check(32'(irq), 32'h0);
        end
        bus(1'b1, OFF_SAMPLE, 32'h4);
        bus(1'b1, OFF_CONV, 32'h5);
        run_one(ctl(MODE_SW, 1'b0, 1'b0, 2'h0, 5'h01), 1);
        check(32'(srun inside {[8:12]}), 32'h1);
        check(32'(crun >= 126), 32'h1);
        run_one(ctl(MODE_SW, 1'b1, 1'b0, 2'h0, 5'h0e), 4);
        for (int j = 0; j < 4; j++) begin
            check(32'(seen_src[j]), 32'(5'h0c + 5'(j)));
            bus(1'b0, OFF_RESULT0 + 8'(4 * j), 0); check(q, 32'({5'h0c + 5'(j), 7'h2b}));
        end
        check(32'(seen_src.size()), 32'h4);
        bus(1'b1, OFF_IRQ_EN, 32'h0);
        run_one(ctl(MODE_SW, 1'b0, 1'b1, 2'h0, 5'h03), 3);
        bus(1'b1, OFF_CMD, 32'h2);
        repeat (10) @(posedge core_clk);
        k = nsmp;
        repeat (300) @(posedge core_clk);
        check(32'(nsmp - k), 32'h0);
        check(32'({adc_sample, adc_convert, irq}), 32'h0);
        bus(1'b0, OFF_IRQ_STAT, 0); check(32'(q[0]), 32'h1);
        bus(1'b1, OFF_IRQ_CLR, 32'h7);
        bus(1'b1, OFF_CTRL, ctl(MODE_HW_NOWAIT, 1'b0, 1'b0, 2'h2, 5'h07));
        seen_src.delete();
        k = nsmp;
        trig(1);
        repeat (40) @(posedge core_clk);
        check(32'(nsmp - k), 32'h0);
        check(32'(adc_power), 32'h1);
        trig(2);
        wait_for(1'b1, nend + 1);
        check(32'(seen_src[0]), 32'h7);
        bus(1'b1, OFF_CTRL, ctl(MODE_HW_WAIT, 1'b0, 1'b0, 2'h0, 5'h09));
        repeat (3) @(posedge core_clk);
        check(32'(adc_power), 32'h0);
        k = nsmp;
        t0 = cyc;
        trig(0);
        @(posedge core_clk);
        check(32'(adc_power), 32'h1);
        wait_for(1'b0, k + 1);
        check(32'(cyc - t0 >= 254), 32'h1);
        trig(0);
        wait_for(1'b1, nend + 1);
        check(32'(seen_src[$]), 32'h9);
        bus(1'b0, OFF_IRQ_STAT, 0); check(32'(q[2]), 32'h1);
        run_one(ctl(MODE_SW, 1'b0, 1'b0, 2'h0, SRC_UNUSED_CH), 0);
        repeat (100) @(posedge core_clk);
        check(32'(seen_src.size()), 32'h0);
        bus(1'b0, OFF_STATUS, 0); check(32'(q[5]), 32'h1);
        wrap_up();
    end
endmodule // sar_adc_ctrl_tb
`default_nettype wire
